// >>> rtl/parallel_camera_capture.sv
module parallel_camera_capture
	import cam_capture_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	// APB slave.
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Camera pins.
	input  wire logic        pixel_clock_in,
	input  wire logic        line_sync_in,
	input  wire logic        frame_sync_in,
	input  wire logic [7:0]  pixel_data_bus,
	output logic             camera_clock_out,
	// System events.
	output logic             rx_data_ready,
	output logic             irq
);

	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	// Configuration registers.
	logic        open_q;              // Unit opened.
	logic        capture_q;           // Capture in progress.
	logic        big_q;               // Big endian packing.
	logic        hpol_q;              // Line sync active low.
	logic        vpol_q;              // Frame sync active low.
	logic [2:0]  div_q;               // Divider code.
	logic [15:0] hstart_q;
	logic [15:0] vstart_q;
	logic [15:0] hcount_q;
	logic [15:0] vcount_q;
	logic [EV_W-1:0] status_q;        // Sticky events.
	logic [EV_W-1:0] mask_q;          // Interrupt enables.

	// Pin synchronisers, two stages each; stage one read only by stage two.
	logic [10:0] pin_s1_q;
	logic [10:0] pin_s2_q;
	logic        pclk_prev_q;         // Delayed stage two pixel clock for edge detect.
	logic        hs_prev_q;           // Previous active line sync.
	logic        vs_prev_q;           // Previous active frame sync.

	// Capture state.
	typedef enum logic [1:0] {IDLE, WAIT_FRAME, ACTIVE} cap_state_e;
	cap_state_e  state_q;
	logic [15:0] px_q;                // Pixel index within line.
	logic [15:0] ln_q;                // Line index within frame.
	logic [15:0] kept_q;              // Lines kept so far.
	logic [1:0]  byte_q;              // Byte slot within word.
	logic [31:0] word_q;              // Word being assembled.
	logic        push_q;              // Push assembled word to buffer.
	logic        frame_end_q;         // One cycle frame end pulse.
	logic        overrun_q;           // One cycle overrun pulse.

	// Bus side.
	logic        fifo_full;
	logic        fifo_empty;
	logic [31:0] fifo_data;
	logic [LW-1:0] fifo_level;
	logic        pop;
	logic        setup_w;
	logic        acc_w;
	logic        pix_edge;
	logic        hs_act;
	logic        vs_act;
	logic        px_in_win;
	logic        ln_in_win;

	// Decode a register access address.
	function automatic logic hit(input logic [11:0] a, input logic [11:0] offs);
		hit = (a == offs);
	endfunction

	assign acc_w    = psel && penable;
	assign setup_w  = psel && !penable;
	assign pop      = setup_w && !pwrite && hit(paddr, DATA_OFFS);  // Pops with the read snapshot.
	assign pix_edge = pin_s2_q[10] && !pclk_prev_q;
	assign hs_act   = pin_s2_q[9] ^ hpol_q;
	assign vs_act   = pin_s2_q[8] ^ vpol_q;
	assign px_in_win = (px_q >= hstart_q) && (px_q < hstart_q + hcount_q);
	assign ln_in_win = (ln_q >= vstart_q) && (kept_q < vcount_q);

	// The pixel clock is sampled as a level in the bus domain, so it must stay under half of it.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_s1_q    <= '0;
			pin_s2_q    <= '0;
			pclk_prev_q <= 1'b0;
		end
		else
		begin
			pin_s1_q    <= {pixel_clock_in, line_sync_in, frame_sync_in, pixel_data_bus};
			pin_s2_q    <= pin_s1_q;
			pclk_prev_q <= pin_s2_q[10];
		end
	end

	// Camera clock generator runs whenever the unit is open.
	clock_divider u_div (
		.pclk     (pclk),
		.presetn  (presetn),
		.run      (open_q),
		.div_code (div_q),
		.clk_out  (camera_clock_out)
	);

	// Frame and line walker, driven by rising pixel clock edges.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q     <= IDLE;
			px_q        <= '0;
			ln_q        <= '0;
			kept_q      <= '0;
			byte_q      <= '0;
			word_q      <= '0;
			push_q      <= 1'b0;
			frame_end_q <= 1'b0;
			hs_prev_q   <= 1'b0;
			vs_prev_q   <= 1'b0;
		end
		else
		begin
			push_q      <= 1'b0;
			frame_end_q <= 1'b0;
			if (pix_edge)
			begin
				hs_prev_q <= hs_act;
				vs_prev_q <= vs_act;
			end
			case (state_q)
				IDLE:
				begin
					// A capture waits for the start of a fresh frame; the camera must already clock.
					if (capture_q && open_q)
						state_q <= WAIT_FRAME;
				end
				WAIT_FRAME:
				begin
					if (!capture_q)
						state_q <= IDLE;
					else if (pix_edge && vs_act && !vs_prev_q)
					begin
						state_q <= ACTIVE;
						px_q    <= '0;
						ln_q    <= '0;
						kept_q  <= '0;
						byte_q  <= '0;
					end
				end
				ACTIVE:
				begin
					if (!capture_q)
						state_q <= IDLE;
					else if (pix_edge)
					begin
						if (hs_act)
						begin
							// Pixel inside the window gets packed.
							if (ln_in_win && px_in_win)
							begin
								if (big_q)
									word_q <= {word_q[23:0], pin_s2_q[7:0]};
								else
									word_q <= {pin_s2_q[7:0], word_q[31:8]};
								byte_q <= byte_q + 2'h1;
								if (byte_q == 2'h3)
									push_q <= 1'b1;
							end
							px_q <= px_q + 16'h1;
						end
						else if (hs_prev_q)
						begin
							// Line ended; count it and check frame completion.
							px_q <= '0;
							ln_q <= ln_q + 16'h1;
							if (ln_in_win)
							begin
								kept_q <= kept_q + 16'h1;
								if (kept_q + 16'h1 == vcount_q)
								begin
									frame_end_q <= 1'b1;
									state_q     <= IDLE;
								end
							end
						end
					end
				end
				default: state_q <= IDLE;
			endcase
		end
	end

	// Buffer between capture and bus; a full buffer drops the word.
	word_fifo #(
		.WIDTH (32),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.pclk     (pclk),
		.presetn  (presetn),
		.flush    (!open_q),
		.wr_valid (push_q),
		.wr_data  (word_q),
		.full     (fifo_full),
		.rd_ready (pop),
		.rd_data  (fifo_data),
		.empty    (fifo_empty),
		.level    (fifo_level)
	);

	// Overrun pulse when a word arrives at a full buffer.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			overrun_q <= 1'b0;
		else
			overrun_q <= push_q && fifo_full;
	end

	// Data ready request while a whole DMA block of eight words waits.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_data_ready <= 1'b0;
		else
			rx_data_ready <= (fifo_level >= LW'(BURST_WORDS));
	end

	// Configuration writes; capture start clears itself at frame end.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			open_q    <= 1'b0;
			capture_q <= 1'b0;
			big_q     <= 1'b0;
			hpol_q    <= 1'b0;
			vpol_q    <= 1'b0;
			div_q     <= DIV_RESET;
			hstart_q  <= HSTART_RESET;
			vstart_q  <= VSTART_RESET;
			hcount_q  <= HCOUNT_RESET;
			vcount_q  <= VCOUNT_RESET;
			mask_q    <= '0;
		end
		else
		begin
			if (frame_end_q)
				capture_q <= 1'b0;
			if (acc_w && pwrite)
			begin
				if (hit(paddr, CTRL_OFFS))
				begin
					open_q    <= pwdata[CTRL_OPEN_BIT];
					capture_q <= pwdata[CTRL_CAPTURE_BIT] && pwdata[CTRL_OPEN_BIT];
					big_q     <= pwdata[CTRL_BIG_BIT];
					hpol_q    <= pwdata[CTRL_HPOL_BIT];
					vpol_q    <= pwdata[CTRL_VPOL_BIT];
					div_q     <= pwdata[CTRL_DIV_LSB +: CTRL_DIV_W];
				end
				if (hit(paddr, HSTART_OFFS)) hstart_q <= pwdata[15:0];
				if (hit(paddr, VSTART_OFFS)) vstart_q <= pwdata[15:0];
				if (hit(paddr, HCOUNT_OFFS)) hcount_q <= pwdata[15:0];
				if (hit(paddr, VCOUNT_OFFS)) vcount_q <= pwdata[15:0];
				if (hit(paddr, MASK_OFFS))   mask_q   <= pwdata[EV_W-1:0];
			end
		end
	end

	// Sticky status cleared with the read snapshot at setup, so no event slips in between; a new one survives.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_q <= '0;
		else
		begin
			if (setup_w && !pwrite && hit(paddr, STATUS_OFFS))
				status_q <= {overrun_q, frame_end_q};
			else
				status_q <= status_q | {overrun_q, frame_end_q};
		end
	end

	// Interrupt level from status, new event pulses and mask.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |((status_q | {overrun_q, frame_end_q}) & mask_q);
	end

	// Read data is prepared in the setup cycle so the access phase ends at once.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= setup_w;
			pslverr <= setup_w && (paddr > STATE_OFFS || paddr[1:0] != 2'h0);
			if (setup_w && !pwrite)
			begin
				case (paddr)
					CTRL_OFFS:   prdata <= {21'h0, div_q, 3'h0, vpol_q, hpol_q, big_q, capture_q, open_q};
					HSTART_OFFS: prdata <= {16'h0, hstart_q};
					VSTART_OFFS: prdata <= {16'h0, vstart_q};
					HCOUNT_OFFS: prdata <= {16'h0, hcount_q};
					VCOUNT_OFFS: prdata <= {16'h0, vcount_q};
					STATUS_OFFS: prdata <= {30'h0, status_q};
					MASK_OFFS:   prdata <= {30'h0, mask_q};
					DATA_OFFS:   prdata <= fifo_empty ? 32'h0 : fifo_data;
					STATE_OFFS:  prdata <= {28'h0, state_q != IDLE, fifo_empty, pin_s2_q[8], pin_s2_q[9]};
					default:     prdata <= 32'h0;
				endcase
			end
			else
				prdata <= '0;
		end
	end

endmodule

// >>> common/cam_capture_pkg.sv
package cam_capture_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [11:0] CTRL_OFFS     = 12'h000;  // Enable, polarities, endian, divider.
	localparam logic [11:0] HSTART_OFFS   = 12'h004;  // First pixel of a line to keep.
	localparam logic [11:0] VSTART_OFFS   = 12'h008;  // First line of a frame to keep.
	localparam logic [11:0] HCOUNT_OFFS   = 12'h00c;  // Pixels kept per line.
	localparam logic [11:0] VCOUNT_OFFS   = 12'h010;  // Lines kept per frame.
	localparam logic [11:0] STATUS_OFFS   = 12'h014;  // Sticky events, cleared by read.
	localparam logic [11:0] MASK_OFFS     = 12'h018;  // Interrupt mask, same layout.
	localparam logic [11:0] DATA_OFFS     = 12'h01c;  // Receive data word, read pops it.
	localparam logic [11:0] STATE_OFFS    = 12'h020;  // Live sync levels and busy flag.

	// Control register field positions.
	localparam int CTRL_OPEN_BIT    = 0;   // Opens the unit, starts the camera clock.
	localparam int CTRL_CAPTURE_BIT = 1;   // Start of capture, cleared at frame end.
	localparam int CTRL_BIG_BIT     = 2;   // Big endian byte order when set.
	localparam int CTRL_HPOL_BIT    = 3;   // Line sync active low when set.
	localparam int CTRL_VPOL_BIT    = 4;   // Frame sync active low when set.
	localparam int CTRL_DIV_LSB     = 8;   // Divider code, factor is 2*(code+1).
	localparam int CTRL_DIV_W       = 3;

	// Status and mask bit positions.
	localparam int EV_FRAME_END_BIT = 0;
	localparam int EV_OVERRUN_BIT   = 1;
	localparam int EV_W             = 2;

	// Reset values of the configuration.
	localparam logic [2:0]  DIV_RESET    = 3'h0;     // Divide by two.
	localparam logic [15:0] HSTART_RESET = 16'h0000;
	localparam logic [15:0] VSTART_RESET = 16'h0000;
	localparam logic [15:0] HCOUNT_RESET = 16'h0280;  // 640 pixels.
	localparam logic [15:0] VCOUNT_RESET = 16'h01e0;  // 480 lines.

	// Words per receive-data-ready request, matching the DMA block size.
	localparam int BURST_WORDS = 8;

endpackage

// >>> rtl/clock_divider.sv
module clock_divider
	import cam_capture_pkg::*;
(
	// Clock and reset.
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Control.
	input  wire logic       run,
	input  wire logic [2:0] div_code,
	// Divided clock.
	output logic            clk_out
);

	logic [3:0] cnt_q;  // Half period counter.
	logic [3:0] half_w; // Half period minus one.

	assign half_w = {1'b0, div_code};

	// Toggle every div_code+1 cycles, giving an even factor 2..16; stopped and low while closed.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q   <= 4'h0;
			clk_out <= 1'b0;
		end
		else if (!run)
		begin
			cnt_q   <= 4'h0;
			clk_out <= 1'b0;
		end
		else if (cnt_q >= half_w)
		begin
			cnt_q   <= 4'h0;
			clk_out <= ~clk_out;
		end
		else
		begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

endmodule

// >>> rtl/word_fifo.sv
module word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Flush, held while the unit is closed.
	input  wire logic             flush,
	// Write side.
	input  wire logic             wr_valid,
	input  wire logic [WIDTH-1:0] wr_data,
	output logic                  full,
	// Read side.
	input  wire logic             rd_ready,
	output logic [WIDTH-1:0]      rd_data,
	output logic                  empty,
	output logic [$clog2(DEPTH):0] level
);

	localparam int AW              = $clog2(DEPTH);
	localparam int BURST_DEPTH_MIN = 8;  // A whole transfer block must fit.

	// Refuse depths that the wrap-bit pointers or the block request cannot serve.
	if (DEPTH < BURST_DEPTH_MIN || (1 << AW) != DEPTH)
	begin
		$error("word_fifo depth must be a power of two of at least eight");
	end

	logic [WIDTH-1:0] mem [DEPTH];  // Word storage.
	logic [AW:0]      wp_q;         // Write pointer with wrap bit.
	logic [AW:0]      rp_q;         // Read pointer with wrap bit.

	assign level   = wp_q - rp_q;
	assign full    = (level == (AW+1)'(DEPTH));
	assign empty   = (wp_q == rp_q);
	assign rd_data = mem[rp_q[AW-1:0]];

	// Storage takes a word only when not full; the caller reports the drop.
	always_ff @(posedge pclk)
	begin
		if (wr_valid && !full)
			mem[wp_q[AW-1:0]] <= wr_data;
	end

	// Pointers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wp_q <= '0;
			rp_q <= '0;
		end
		else if (flush)
		begin
			wp_q <= '0;
			rp_q <= '0;
		end
		else
		begin
			if (wr_valid && !full)
				wp_q <= wp_q + 1'b1;
			if (rd_ready && !empty)
				rp_q <= rp_q + 1'b1;
		end
	end

endmodule

// >>> verification/cam_capture_chk.sv
module cam_capture_chk
	import cam_capture_pkg::*;
(
	// Bus side.
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Camera and events.
	input wire logic        camera_clock_out,
	input wire logic        rx_data_ready,
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       open_q;  // Open bit as last written.
	logic [2:0] div_q;   // Divider code as last written.
	logic [1:0] mask_q;  // Event mask as last written.
	logic       prev_q;  // Camera clock one cycle ago.
	logic       seen_q;  // A toggle was seen since opening.
	logic [4:0] run_q;   // Cycles the camera clock held its level.
	wire        wr_done = psel && penable && pready && pwrite;
	wire        tog     = camera_clock_out != prev_q;
	wire        bad     = paddr > STATE_OFFS || paddr[1:0] != 2'h0;
	// Shadow copies follow only completed writes, as the unit does.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			open_q <= 1'b0;
			div_q  <= 3'h0;
			mask_q <= 2'h0;
		end
		else if (wr_done && paddr == CTRL_OFFS)
		begin
			open_q <= pwdata[CTRL_OPEN_BIT];
			div_q  <= pwdata[CTRL_DIV_LSB +: CTRL_DIV_W];
		end
		else if (wr_done && paddr == MASK_OFFS)
			mask_q <= pwdata[1:0];
	// The first half period after opening includes the closed time, so it is not measured.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			prev_q <= 1'b0;
			run_q  <= 5'h0;
			seen_q <= 1'b0;
		end
		else
		begin
			prev_q <= camera_clock_out;
			run_q  <= tog ? 5'h1 : run_q + 5'h1;
			seen_q <= open_q && (seen_q || tog);
		end
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence closed_s;
		!open_q [*3];
	endsequence
	apb_zero_wait_a: assert property (setup_s |=> pready) else $error("ready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("stray error");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
	bad_addr_a: assert property (psel && !penable && bad |=> pslverr) else $error("no error");
	good_addr_a: assert property (psel && !penable && !bad |=> !pslverr) else $error("false error");
	clock_closed_a: assert property (closed_s |-> !camera_clock_out) else $error("clock runs");
	clock_div_a: assert property (tog && seen_q && open_q |-> run_q == {2'h0, div_q} + 5'h1)
		else $error("half period wrong");
	flush_closed_a: assert property (closed_s |-> !rx_data_ready) else $error("data kept");
	irq_masked_a: assert property (mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !irq) else $error("irq");
endmodule

bind parallel_camera_capture cam_capture_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .camera_clock_out(camera_clock_out), .rx_data_ready(rx_data_ready), .irq(irq));

// >>> verification/camera_model.sv
module camera_model
(
	// Camera pins toward the unit.
	output logic       pixel_clock_in,
	output logic       line_sync_in,
	output logic       frame_sync_in,
	output logic [7:0] pixel_data_bus
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hidle; // Idle line sync level.
	logic vidle; // Idle frame sync level.
	int   half;  // Half period of the pixel clock in ns.
	initial
	begin
		{pixel_clock_in, line_sync_in, frame_sync_in, hidle, vidle} = 5'h0;
		pixel_data_bus = 8'h00;
		half = 250;
	end
	// Idle levels must be set before the unit learns the polarity.
	task automatic park(input logic hp, input logic vp);
		hidle = hp;
		vidle = vp;
		line_sync_in = hp;
		frame_sync_in = vp;
	endtask
	// The pixel clock runs only around frames; data moves on falls only.
	task automatic tick(input int n);
		repeat (n)
		begin
			#(half) pixel_clock_in = 1'b1;
			#(half) pixel_clock_in = 1'b0;
		end
	endtask
	// Sends nl lines of np pixels, byte values counting up from b0.
	task automatic frame(input int nl, input int np, input logic [7:0] b0, input int hp);
		#13;
		half = hp;
		tick(4);
		frame_sync_in = !vidle;
		tick(2);
		for (int l = 0; l < nl; l++)
		begin
			line_sync_in = !hidle;
			for (int p = 0; p < np; p++)
			begin
				pixel_data_bus = b0 + 8'(l * np + p);
				tick(1);
			end
			line_sync_in = hidle;
			pixel_data_bus = ~pixel_data_bus; // A stale pixel must not pass.
			tick(3);
		end
		frame_sync_in = vidle;
		tick(2);
	endtask
endmodule

// >>> verification/test_parallel_camera_capture.sv
module test_parallel_camera_capture
	import cam_capture_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pixel_clock_in, line_sync_in, frame_sync_in, camera_clock_out, rx_data_ready, irq;
	logic [7:0]  pixel_data_bus;
	logic [31:0] exp_q[$]; // Expected read data, oldest first.
	int          n_errors, checked;
	parallel_camera_capture u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pixel_clock_in(pixel_clock_in), .line_sync_in(line_sync_in), .frame_sync_in(frame_sync_in),
		.pixel_data_bus(pixel_data_bus), .camera_clock_out(camera_clock_out),
		.rx_data_ready(rx_data_ready), .irq(irq));
	camera_model u_cam (.pixel_clock_in(pixel_clock_in), .line_sync_in(line_sync_in),
		.frame_sync_in(frame_sync_in), .pixel_data_bus(pixel_data_bus));
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, seen, want);
		end
	endtask
	// One bus transfer; an idle cycle follows so no signal is set twice at one edge.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
			chk(32'h0, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask
	// Each completed read takes the oldest expectation off the queue.
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk(prdata, exp_q.pop_front());
	task automatic print_verdict;
		$display("checked %0d, n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Watchdog, far beyond the few thousand cycles the run needs.
	initial
	begin
		#3000000;
		n_errors++;
		print_verdict;
	end
	initial
	begin
		logic [7:0]  b0;
		logic [31:0] w;
		int          hs;
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		void'($urandom(32'hc9d2));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(CTRL_OFFS, 32'h0);
		rd(HSTART_OFFS, 32'h0);
		rd(VSTART_OFFS, 32'h0);
		rd(HCOUNT_OFFS, 32'h280);
		rd(VCOUNT_OFFS, 32'h1e0);
		rd(12'h024, 32'h0);
		// Every divider code, closing between codes so no half period is mixed.
		for (int c = 0; c < 8; c++)
		begin
			wr(CTRL_OFFS, 32'h0);
			wr(CTRL_OFFS, (32'(c) << CTRL_DIV_LSB) | 32'h1);
			repeat (40) @(posedge pclk);
		end
		// Close before the capture setup changes the divider, so no half period is mixed.
		wr(CTRL_OFFS, 32'h0);
		wr(MASK_OFFS, 32'h1);
		// Little order with high syncs, then big order with low syncs and a slow camera.
		for (int m = 0; m < 2; m++)
		begin
			b0 = 8'($urandom);
			hs = $urandom_range(3);
			u_cam.park(m[0], m[0]);
			wr(HSTART_OFFS, 32'(hs));
			wr(VSTART_OFFS, 32'h1);
			wr(HCOUNT_OFFS, 32'h10);
			wr(VCOUNT_OFFS, 32'h2);
			wr(CTRL_OFFS, {27'h0, m[0], m[0], m[0], 2'h3});
			u_cam.frame(3, 20, b0, m ? 450 : 250);
			for (int t = 0; t < 200 && irq !== 1'b1; t++)
				@(posedge pclk);
			chk({31'h0, irq}, 32'h1);
			chk({31'h0, rx_data_ready}, 32'h1);
			for (int k = 0; k < 8; k++)
			begin
				for (int bt = 0; bt < 4; bt++)
					w[(m ? 3 - bt : bt) * 8 +: 8] = b0 + 8'((1 + k / 4) * 20 + hs + (k % 4) * 4 + bt);
				rd(DATA_OFFS, w);
			end
			rd(STATUS_OFFS, 32'h1);
			@(posedge pclk);
			chk({30'h0, irq, rx_data_ready}, 32'h0);
		end
		// Twenty words into a sixteen-word buffer with nobody draining.
		u_cam.park(1'b0, 1'b0);
		wr(MASK_OFFS, 32'h2);
		wr(HSTART_OFFS, 32'h0);
		wr(VCOUNT_OFFS, 32'h5);
		wr(CTRL_OFFS, 32'h3);
		u_cam.frame(6, 16, 8'h00, 250);
		chk({31'h0, irq}, 32'h1);
		rd(STATUS_OFFS, 32'h3);
		wr(CTRL_OFFS, 32'h0);
		rd(DATA_OFFS, 32'h0);
		rd(STATE_OFFS, 32'h4);
		@(posedge pclk);
		chk({30'h0, irq, rx_data_ready}, 32'h0);
		print_verdict;
	end
endmodule
